// ---- hdl/can_rx_store.sv ----
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module can_rx_store
  import rx_store_pkg::*;
(
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        rst_b_i,
  // buffer configuration from the message buffer array
  input  wire logic [NUM_BUF*ID_W-1:0]     buf_id_i,
  input  wire logic [NUM_BUF*ID_W-1:0]     buf_mask_i,
  input  wire logic [NUM_BUF*TYPE_W-1:0]   buf_type_i,
  input  wire logic [NUM_BUF-1:0]          buf_ready_i,
  input  wire logic [NUM_BUF-1:0]          overwrite_select_i,
  // accepted frame from the protocol engine
  input  wire logic                        frame_valid_i,
  input  wire logic [ID_W-1:0]             frame_id_i,
  input  wire logic [TYPE_W-1:0]           frame_type_i,
  input  wire logic                        frame_remote_i,
  output logic                             frame_ready_o,
  // store result toward the buffer array
  output logic                             store_valid_o,
  output logic [BUF_IDX_W-1:0]             store_index_o,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]           address_i,
  input  wire logic                        read_i,
  input  wire logic                        write_i,
  input  wire logic [DATA_W-1:0]           writedata_i,
  output logic [DATA_W-1:0]                readdata_o,
  output logic                             waitrequest_o,
  // interrupt
  output logic                             irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  store_state_t                 state;
  logic [NUM_BUF-1:0]           new_data_flag;
  logic [BUF_IDX_W-1:0]         hist_mem [HIST_DEPTH];
  logic [HIST_PTR_W-1:0]        hist_wr;
  logic [HIST_PTR_W-1:0]        hist_rd;
  logic [HIST_CNT_W-1:0]        hist_cnt;
  logic                         rx_history_overflow_flag;
  logic                         rx_history_empty_flag;
  logic [IRQ_W-1:0]             irq_stat;
  logic [IRQ_W-1:0]             irq_mask;
  // high for the answer cycle after a request is taken
  logic                         bus_done;
  logic [ID_W-1:0]              lat_id;
  logic [TYPE_W-1:0]            lat_type;
  logic                         lat_remote;

  // ----------------------------------------------------------------
  // match logic
  // ----------------------------------------------------------------
  // per-buffer bits come from generate assigns, hence nets
  // all compares run in parallel: area traded for a one-cycle decision
  wire  [NUM_BUF-1:0] id_hit;
  wire  [NUM_BUF-1:0] group_hit;
  wire  [NUM_BUF-1:0] cand;
  wire  [NUM_BUF-1:0] blocked;

  // masked compare per buffer; type must equal frame type
  genvar g;
  generate
    for (g = 0; g < NUM_BUF; g++)
    begin : g_match
      wire [ID_W-1:0] m = buf_mask_i[g*ID_W +: ID_W];
      assign id_hit[g] = ((lat_id & m) == (buf_id_i[g*ID_W +: ID_W] & m));
      // same type plus same masked id forms the group, gated by buf_ready_i
      assign group_hit[g] = buf_ready_i[g] & id_hit[g]
                            & (buf_type_i[g*TYPE_W +: TYPE_W] == lat_type);
      // a full buffer with a hit above it blocks lower buffers: no wrap
      if (g == NUM_BUF-1)
      begin : g_top
        assign blocked[g] = 1'b0;
      end
      else
      begin : g_low
        assign blocked[g] = |(group_hit[NUM_BUF-1:g+1] & new_data_flag[NUM_BUF-1:g+1]);
      end
      // remote: any matching tx buffer, overwrite select ignored
      // data: vacant, or overwrite allowed, and not behind a used buffer
      assign cand[g] = lat_remote
                       ? (group_hit[g] & (lat_type == TYPE_TX))
                       : (group_hit[g] & ~blocked[g]
                          & (~new_data_flag[g] | overwrite_select_i[g]));
    end
  endgenerate

  // lowest-numbered candidate wins
  logic                 found;
  logic [BUF_IDX_W-1:0] pick;
  always_comb
  begin
    found = 1'b0;
    pick  = '0;
    for (int i = NUM_BUF-1; i >= 0; i--)
    begin
      if (cand[i])
      begin
        found = 1'b1;
        pick  = BUF_IDX_W'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // writes and pops commit on the first edge of a request; the master
  // holds it through the wait state anyway, so nothing is seen twice
  wire bus_req   = (read_i | write_i) & ~bus_done;
  wire rd_hist   = read_i & bus_req & (address_i == REG_HIST);
  wire rd_irq    = read_i & bus_req & (address_i == REG_IRQ_STAT);
  wire wr_mask   = write_i & bus_req & (address_i == REG_IRQ_MASK);
  wire wr_clear  = write_i & bus_req & (address_i == REG_CLEAR);
  // reads of the list allowed in overflow too, until empty
  wire pop       = rd_hist & ~rx_history_empty_flag;
  wire clr_ovf   = wr_clear & writedata_i[ST_OVF];
  wire do_store  = (state == ST_STORE) & found;
  wire do_drop   = (state == ST_STORE) & ~found;
  wire hist_full = (hist_cnt == HIST_CNT_W'(HIST_DEPTH));
  wire push      = do_store & ~hist_full;
  // list storage has no reset; the head reads zero while the list shows empty
  wire [BUF_IDX_W-1:0] hist_head = rx_history_empty_flag ? '0 : hist_mem[hist_rd];

  // one wait state: request seen, answered next edge
  assign waitrequest_o = (read_i | write_i) & ~bus_done;
  assign frame_ready_o = (state == ST_IDLE);
  assign irq_o         = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // frame store engine
  // ----------------------------------------------------------------
  // two-step: latch frame, then decide with stable inputs
  // limitation: one frame every two cycles, back-pressure via frame_ready_o
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      state      <= ST_IDLE;
      lat_id     <= '0;
      lat_type   <= '0;
      lat_remote <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (frame_valid_i)
          begin
            lat_id     <= frame_id_i;
            lat_type   <= frame_type_i;
            lat_remote <= frame_remote_i;
            state      <= ST_STORE;
          end
        end
        ST_STORE: state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // store pulse and new-data flags
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      store_valid_o <= 1'b0;
      store_index_o <= '0;
      new_data_flag <= '0;
    end
    else
    begin
      store_valid_o <= do_store;
      if (do_store)
        store_index_o <= pick;
      // set wins over a same-cycle software clear
      new_data_flag <= (new_data_flag
                        & ~((wr_clear ? writedata_i[CLR_ND_LSB +: NUM_BUF] : '0)))
                       | (do_store ? (NUM_BUF'(1) << pick) : '0);
    end
  end

  // ----------------------------------------------------------------
  // receive history list
  // ----------------------------------------------------------------
  // storage only; unknowns never reach the bus since the head is masked
  always_ff @(posedge clock_i)
  begin
    if (push)
      hist_mem[hist_wr] <= pick;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      hist_wr  <= '0;
      hist_rd  <= '0;
      hist_cnt <= '0;
    end
    else
    begin
      if (push)
        hist_wr <= hist_wr + 1'b1;
      if (pop)
        hist_rd <= hist_rd + 1'b1;
      hist_cnt <= hist_cnt + HIST_CNT_W'(push) - HIST_CNT_W'(pop);
    end
  end

  // overflow sticks until written clear; store while full sets it
  // a store into a full list loses only the new index, never an older one
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      rx_history_overflow_flag <= 1'b0;
    else if (do_store & hist_full)
      rx_history_overflow_flag <= 1'b1;
    else if (clr_ovf)
      rx_history_overflow_flag <= 1'b0;
  end

  // empty flag: set on last pop; a store clears it only outside overflow
  wire last_pop = pop & (hist_cnt == HIST_CNT_W'(1)) & ~push;
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      rx_history_empty_flag <= 1'b1;
    else if (last_pop)
      rx_history_empty_flag <= 1'b1;
    else if (push & ~rx_history_overflow_flag)
      rx_history_empty_flag <= 1'b0;
    // leaving overflow: show entries stored meanwhile, this cycle's too
    else if (clr_ovf & ((hist_cnt != '0) | push))
      rx_history_empty_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // interrupts and bus answer
  // ----------------------------------------------------------------
  // sticky events; event wins over read clear
  // mask gates only the output, so software can still poll every event
  wire [IRQ_W-1:0] irq_evt = {do_store & hist_full, do_drop, do_store};
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      irq_stat <= '0;
      irq_mask <= IRQ_MASK_RST;
      bus_done <= 1'b0;
    end
    else
    begin
      irq_stat <= (rd_irq ? '0 : irq_stat) | irq_evt;
      if (wr_mask)
        irq_mask <= writedata_i[IRQ_W-1:0];
      bus_done <= bus_req;
    end
  end

  // read mux, registered; unmapped reads zero
  logic [DATA_W-1:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    case (address_i)
      REG_STATUS:   rd_mux = {30'h0, rx_history_empty_flag, rx_history_overflow_flag};
      REG_HIST:     rd_mux = {28'h0, rx_history_empty_flag, hist_head};
      REG_IRQ_STAT: rd_mux = {29'h0, irq_stat};
      REG_IRQ_MASK: rd_mux = {29'h0, irq_mask};
      REG_NEWDATA:  rd_mux = {24'h0, new_data_flag};
      default:      rd_mux = '0;
    endcase
  end

  // captured at the taking edge, stands through the answer cycle
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      readdata_o <= '0;
    else if (read_i & bus_req)
      readdata_o <= rd_mux;
  end

endmodule // can_rx_store

// ---- include/rx_store_pkg.sv ----
package rx_store_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_BUF    = 8;
  localparam int BUF_IDX_W  = 3;
  localparam int ID_W       = 29;
  localparam int TYPE_W     = 3;
  localparam int HIST_DEPTH = 8;
  localparam int HIST_PTR_W = 3;
  localparam int HIST_CNT_W = 4;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 4;

  // ----------------------------------------------------------------
  // buffer types
  // ----------------------------------------------------------------
  localparam logic [TYPE_W-1:0] TYPE_TX = 3'h0;

  // ----------------------------------------------------------------
  // register offsets (word index on address_i)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_HIST     = 4'h1;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h3;
  localparam logic [ADDR_W-1:0] REG_NEWDATA  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CLEAR    = 4'h5;

  // status bit positions
  localparam int ST_OVF   = 0;
  localparam int ST_EMPTY = 1;

  // clear register: lowest new-data clear bit
  localparam int CLR_ND_LSB = 8;

  // irq bit positions
  localparam int IRQ_STORED  = 0;
  localparam int IRQ_DROP    = 1;
  localparam int IRQ_OVF     = 2;
  localparam int IRQ_W       = 3;

  // reset values
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // store engine states
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b01,
    ST_STORE = 2'b10
  } store_state_t;
endpackage

// ---- sim/can_engine_model.sv ----
`timescale 1ns/1ps
module can_engine_model
  import rx_store_pkg::*;
(
  // handshake toward the store block
  input  wire logic          clock_i,
  input  wire logic          frame_ready_i,
  output logic               frame_valid_o,
  output logic [ID_W-1:0]    frame_id_o,
  output logic [TYPE_W-1:0]  frame_type_o,
  output logic               frame_remote_o
);
  logic hang = 1'b0;
  initial {frame_valid_o, frame_id_o, frame_type_o, frame_remote_o} = '0;
  // hold the frame until taken; released lines get scrambled, not kept
  task automatic send(input logic [ID_W-1:0] id, input logic [TYPE_W-1:0] ty,
                      input logic rm);
    int   n;
    logic ok;
    n = 0;
    @(posedge clock_i);
    frame_valid_o <= 1'b1;
    frame_id_o <= id;
    frame_type_o <= ty;
    frame_remote_o <= rm;
    do
    begin
      @(negedge clock_i);
      ok = frame_ready_i;
      @(posedge clock_i);
      n++;
    end while (!ok && n < 20);
    hang = !ok;
    frame_valid_o <= 1'b0;
    frame_id_o <= ~id;
    frame_type_o <= ~ty;
    frame_remote_o <= ~rm;
  endtask
endmodule // can_engine_model

// ---- sim/can_rx_store_monitor.sv ----
`timescale 1ns/1ps
module can_rx_store_monitor
  import rx_store_pkg::*;
(
  // clock and reset
  input wire logic                      clock_i,
  input wire logic                      rst_b_i,
  // buffer setup
  input wire logic [NUM_BUF*ID_W-1:0]   buf_id_i,
  input wire logic [NUM_BUF*ID_W-1:0]   buf_mask_i,
  input wire logic [NUM_BUF*TYPE_W-1:0] buf_type_i,
  input wire logic [NUM_BUF-1:0]        buf_ready_i,
  // frame and store
  input wire logic                      frame_valid_i,
  input wire logic [ID_W-1:0]           frame_id_i,
  input wire logic [TYPE_W-1:0]         frame_type_i,
  input wire logic                      frame_remote_i,
  input wire logic                      frame_ready_o,
  input wire logic                      store_valid_o,
  input wire logic [BUF_IDX_W-1:0]      store_index_o,
  // bus and interrupt
  input wire logic [ADDR_W-1:0]         address_i,
  input wire logic                      read_i,
  input wire logic                      write_i,
  input wire logic [DATA_W-1:0]         writedata_i,
  input wire logic                      waitrequest_o,
  input wire logic                      irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire  [NUM_BUF-1:0]   rhit;
  logic [BUF_IDX_W-1:0] rlow;
  wire              take = frame_valid_i && frame_ready_o;
  wire [ID_W-1:0]   sid  = buf_id_i[store_index_o*ID_W+:ID_W];
  wire [ID_W-1:0]   smsk = buf_mask_i[store_index_o*ID_W+:ID_W];
  // transmit buffers a remote frame may land in
  for (genvar g = 0; g < NUM_BUF; g++)
  begin : g_hit
    assign rhit[g] = buf_ready_i[g] && buf_type_i[g*TYPE_W+:TYPE_W] == TYPE_TX
      && ((buf_id_i[g*ID_W+:ID_W] ^ frame_id_i) & buf_mask_i[g*ID_W+:ID_W]) == '0;
  end
  // lowest hit wins, so scan downward
  always_comb
  begin
    rlow = '0;
    for (int g = NUM_BUF - 1; g >= 0; g--)
      if (rhit[g]) rlow = g[BUF_IDX_W-1:0];
  end
  AST_STORE_CAUSE: assert property (store_valid_o |-> $past(take, 2))
    else $error("store without a frame two cycles before");
  AST_STORE_PULSE: assert property (store_valid_o |=> !store_valid_o)
    else $error("store pulse longer than one cycle");
  AST_BUSY_AFTER_TAKE: assert property (take |=> !frame_ready_o)
    else $error("frame taken while previous in flight");
  AST_TYPE_MATCH: assert property (store_valid_o |->
    buf_type_i[store_index_o*TYPE_W+:TYPE_W] == $past(frame_type_i, 2))
    else $error("frame stored in buffer of other type");
  AST_MASKED_ID: assert property (store_valid_o |->
    ((sid ^ $past(frame_id_i, 2)) & smsk) == '0)
    else $error("frame stored in buffer with other masked id");
  AST_REMOTE_LOW: assert property (take && frame_remote_i && rhit != '0 |->
    ##2 store_valid_o && store_index_o == $past(rlow, 2))
    else $error("remote frame not in lowest transmit buffer");
  AST_BUS_WAIT: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("bus answer later than one wait state");
  AST_IRQ_MASK: assert property (write_i && !waitrequest_o && address_i == REG_IRQ_MASK
    && writedata_i[IRQ_W-1:0] == '0 |=> !irq_o)
    else $error("interrupt high with all sources masked");
  COV_STORE: cover property (store_valid_o);
  COV_REMOTE: cover property (take && frame_remote_i);
  COV_IRQ: cover property (irq_o);
endmodule // can_rx_store_monitor

// ---- sim/test_can_rx_store.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end
module test_can_rx_store;
  import rx_store_pkg::*;
  localparam logic [ID_W-1:0]   ID_A = 29'h00001AA;
  localparam logic [ID_W-1:0]   ID_R = 29'h0000333;
  localparam logic [DATA_W-1:0] ALL  = 32'hFFFFFFFF;
  // group 1..2 type 1 masked ids, 3 type 5 same masked id, 4..5 transmit
  logic [NUM_BUF*ID_W-1:0]   buf_id_i   = {{2{29'h0}}, {2{ID_R}}, 29'h100,
                                           29'h155, 29'h120, 29'h0};
  logic [NUM_BUF*ID_W-1:0]   buf_mask_i = {{4{29'h1FFFFFFF}}, {3{29'h1FFFFF00}},
                                           29'h1FFFFFFF};
  logic [NUM_BUF*TYPE_W-1:0] buf_type_i = 24'hD80A4B;
  logic [NUM_BUF-1:0]        buf_ready_i = 8'hFF;
  logic [NUM_BUF-1:0]        overwrite_select_i = 8'h00;
  logic                      clock_i = 1'b0;
  logic                      rst_b_i = 1'b0;
  logic                      read_i = 1'b0;
  logic                      write_i = 1'b0;
  logic [ADDR_W-1:0]         address_i = '0;
  logic [DATA_W-1:0]         writedata_i = '0;
  logic [DATA_W-1:0]         readdata_o;
  logic                      waitrequest_o, irq_o, frame_ready_o, store_valid_o;
  logic                      frame_valid_i, frame_remote_i;
  logic [ID_W-1:0]           frame_id_i;
  logic [TYPE_W-1:0]         frame_type_i;
  logic [BUF_IDX_W-1:0]      store_index_o;
  int                        num_errors = 0;
  int                        total_checks = 0;
  initial forever #50 clock_i = ~clock_i;
  can_rx_store u_can_rx_store (.*);
  can_engine_model u_can_engine_model (.clock_i(clock_i), .frame_ready_i(frame_ready_o),
    .frame_valid_o(frame_valid_i), .frame_id_o(frame_id_i),
    .frame_type_o(frame_type_i), .frame_remote_o(frame_remote_i));
  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one bus cycle, held through the rising edge after waitrequest is seen low at a falling edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    int   n;
    logic w;
    n = 0;
    @(posedge clock_i);
    address_i <= a;
    writedata_i <= d;
    read_i <= !wr;
    write_i <= wr;
    do
    begin
      @(negedge clock_i);
      w = waitrequest_o;
      q = readdata_o;
      @(posedge clock_i);
      n++;
    end while (w !== 1'b0 && n < 20);
    read_i <= 1'b0;
    write_i <= 1'b0;
    if (w !== 1'b0)
    begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, m,
                    input string n);
    logic [DATA_W-1:0] q;
    bus(1'b0, a, '0, q);
    `CHK(n, e, q & m)
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    bus(1'b1, a, d, q);
  endtask
  // offer a frame, then expect a store pulse at the stated index or none
  task automatic frm(input logic [ID_W-1:0] id, input logic [TYPE_W-1:0] ty,
                     input logic rm, ok, input logic [BUF_IDX_W-1:0] ix);
    u_can_engine_model.send(id, ty, rm);
    if (u_can_engine_model.hang)
    begin
      num_errors++;
      finish_test();
    end
    @(posedge clock_i);
    @(negedge clock_i);
    `CHK("store", ok, store_valid_o)
    if (ok) `CHK("index", ix, store_index_o)
    repeat (2) @(posedge clock_i);
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(REG_STATUS, 32'h2, ALL, "status");
    @(negedge clock_i);
    `CHK("irq", 1'b0, irq_o)
    frm(ID_A, 3'h1, 1'b0, 1'b1, 3'h1);
    frm(ID_A, 3'h1, 1'b0, 1'b1, 3'h2);
    rd(REG_NEWDATA, 32'h6, ALL, "newdata");
    wr(REG_CLEAR, 32'h200);
    frm(ID_A, 3'h1, 1'b0, 1'b0, 3'h0);
    frm(ID_R, TYPE_TX, 1'b1, 1'b1, 3'h4);
    frm(ID_R, TYPE_TX, 1'b1, 1'b1, 3'h4);
    rd(REG_NEWDATA, 32'h14, ALL, "newdata");
    for (int i = 0; i < 4; i++) rd(REG_HIST, i < 2 ? i + 1 : 4, 32'hF, "history");
    rd(REG_HIST, 32'h8, 32'h8, "history");
    repeat (9) frm(ID_R, TYPE_TX, 1'b1, 1'b1, 3'h4);
    rd(REG_STATUS, 32'h1, ALL, "status");
    repeat (8) rd(REG_HIST, 32'h4, 32'hF, "history");
    rd(REG_STATUS, 32'h3, ALL, "status");
    frm(ID_R, TYPE_TX, 1'b1, 1'b1, 3'h4);
    rd(REG_STATUS, 32'h3, ALL, "status");
    wr(REG_CLEAR, 32'h1);
    rd(REG_STATUS, 32'h0, ALL, "status");
    wr(REG_IRQ_MASK, 32'h7);
    @(negedge clock_i);
    `CHK("irq", 1'b1, irq_o)
    rd(REG_IRQ_STAT, 32'h7, ALL, "irqstat");
    @(negedge clock_i);
    `CHK("irq", 1'b0, irq_o)
    wr(REG_IRQ_MASK, 32'h0);
    rd(4'hF, 32'h0, ALL, "unmapped");
    finish_test();
  end
endmodule // test_can_rx_store
bind can_rx_store can_rx_store_monitor u_can_rx_store_monitor (.*);
